// ### sim/rxcfg_bank_assertions.sv
// Checker for the receiver configuration bank, watching the top ports only.
// Bound from the bench top; decoded outputs lag a taken write by two edges.
`timescale 1ns/1ps
`include "rxcfg_defines.vh"
module rxcfg_bank_checker #(
   parameter SQUELCH_DELAY_CYC = `RXCFG_SQUELCH_DELAY_CYC,
   parameter MASK_STEP_CARRIERS = `RXCFG_MASK_STEP_CARRIERS
) (
   input wire i_clk, input wire i_rst_n,
   input wire i_reg_wr, input wire i_reg_rd, input wire [5:0] i_reg_addr, input wire [7:0] i_reg_wdata,
   input wire [7:0] o_reg_rdata, input wire o_reg_rvalid,
   input wire i_set_default, input wire i_tx_end, input wire i_single_ended_drv,
   input wire o_receiver_low_power, input wire [2:0] o_am_first_stage_gain, input wire [2:0] o_lowpass_code,
   input wire o_nfc_forced_gain, input wire o_agc_enable, input wire o_pm_mixer_clock_source,
   input wire o_squelch_active, input wire o_rx_masked
);
   localparam SQD = SQUELCH_DELAY_CYC + 1;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire wr_ok = i_reg_wr && !i_set_default;
   wire unmapped = i_reg_addr < `RXCFG_OFS_CHANNEL_FILTER || i_reg_addr > `RXCFG_OFS_FIRST_GAIN;
   read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   valid_pulse_a: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("stray read valid");
   unmapped_zero_a: assert property (i_reg_rd && unmapped |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   lowpass_code_a: assert property (wr_ok && i_reg_addr == `RXCFG_OFS_CHANNEL_FILTER
      |-> ##2 o_lowpass_code == $past(i_reg_wdata[5:3], 2)) else $error("lowpass code wrong");
   low_power_a: assert property (wr_ok && i_reg_addr == `RXCFG_OFS_MODE_GAIN
      |-> ##2 o_receiver_low_power == $past(i_reg_wdata[7], 2)) else $error("low power wrong");
   am_gain_a: assert property (wr_ok && i_reg_addr == `RXCFG_OFS_FIRST_GAIN
      |-> ##2 o_am_first_stage_gain == $past(i_reg_wdata[7:5], 2)) else $error("am gain wrong");
   nfc_gain_a: assert property (wr_ok && i_reg_addr == `RXCFG_OFS_FIRST_GAIN
      |-> ##2 o_nfc_forced_gain == $past(i_reg_wdata[0], 2)) else $error("nfc gain wrong");
   mixer_forced_a: assert property ($past(i_rst_n) && $past(i_single_ended_drv) |-> o_pm_mixer_clock_source)
      else $error("mixer clock not internal");
   default_load_a: assert property (i_set_default
      |-> ##2 o_agc_enable && o_am_first_stage_gain == 3'b110 && !o_nfc_forced_gain) else $error("no default");
   mask_start_a: assert property (i_tx_end |=> o_rx_masked) else $error("mask not started");
   squelch_mask_a: assert property (o_squelch_active |-> o_rx_masked) else $error("squelch past mask");
   squelch_delay_a: assert property ($rose(o_squelch_active) |-> $past(i_tx_end, SQD))
      else $error("squelch start late or early");
   cover property (i_tx_end ##1 o_rx_masked [*3]);
   cover property (i_set_default && i_reg_wr);
   cover property ($rose(o_squelch_active));
endmodule

// ### sim/rxcfg_bank_tb_top.sv
// Bench for the receiver configuration bank with a scoreboard of the three registers.
// Inputs change on the falling edge; mask step and squelch delay are shortened to 4 ticks.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin fail_count++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module rxcfg_bank_tb_top;
   reg i_clk = 1'b0, i_rst_n = 1'b0, i_set_default = 1'b0, i_tx_end = 1'b0, i_carrier_tick = 1'b0;
   reg [7:0] i_mask_rx_steps = 8'h02;
   reg i_am_chan_enabled = 1'b1, i_pm_chan_enabled = 1'b0, i_manual_chan_sel = 1'b0, i_single_ended_drv = 1'b0;
   wire i_reg_wr, i_reg_rd, o_reg_rvalid, o_am_chan_on, o_pm_chan_on, o_framing_uses_pm, o_am_demod_mixer;
   wire [5:0] i_reg_addr;
   wire [7:0] i_reg_wdata, o_reg_rdata;
   wire [2:0] o_lowpass_code, o_am_first_stage_gain, o_pm_first_stage_gain;
   wire o_zero_setting_high, o_zero_setting_mid, o_zero_setting_low, o_receiver_low_power, o_low_freq_input_split;
   wire o_lf_on_input, o_agc_enable, o_agc_whole_period, o_agc_alg_reset, o_pm_mixer_clock_source;
   wire o_clip_stages, o_nfc_forced_gain, o_squelch_active, o_rx_masked;
   wire [6:0] dec1 = {o_am_demod_mixer, o_lowpass_code, o_zero_setting_high, o_zero_setting_mid, o_zero_setting_low};
   wire [6:0] dec2 = {o_receiver_low_power, o_low_freq_input_split, o_lf_on_input, o_agc_enable,
      o_agc_whole_period, o_agc_alg_reset, o_pm_mixer_clock_source};
   wire [7:0] dec3 = {o_am_first_stage_gain, o_pm_first_stage_gain, o_clip_stages, o_nfc_forced_gain};
   reg [7:0] m [0:2];
   reg [7:0] seed = 8'h0d, rd_d;
   reg rd_v, sq;
   integer fail_count = 0, n_checks = 0, cyc = 0, i, k;
   rxcfg_bank #(.SQUELCH_DELAY_CYC(4), .MASK_STEP_CARRIERS(4)) rxcfg_bank_inst (.*);
   rxcfg_host_model host_inst (.i_clk(i_clk), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_wr(i_reg_wr),
      .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
   always #2.5 i_clk = ~i_clk;
   function [7:0] lfsr(input [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task check_reg(input [5:0] a);
      begin
         host_inst.rd(a, rd_d, rd_v);
         `CHK("rvalid", 1'b1, rd_v)
         `CHK("rdata", (a >= 6'h0a && a <= 6'h0c) ? m[a - 6'h0a] : 8'h00, rd_d)
      end
   endtask
   task check_dec;
      begin
         @(negedge i_clk);
         `CHK("cfg1", m[0][6:0], dec1)
         `CHK("cfg2", {m[1][7:2], m[1][0] | i_single_ended_drv}, dec2)
         `CHK("cfg3", m[2], dec3)
      end
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run;
      end
   end
   initial begin
      m[0] = 8'h00;
      m[1] = 8'h1a;
      m[2] = 8'hd8;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk) i_rst_n = 1'b1;
      check_dec;
      for (k = 8; k < 14; k++) check_reg(k[5:0]);
      for (i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         k = 10 + i % 4;
         host_inst.wr(k[5:0], seed);
         if (k < 13) m[k - 10] = seed;
         i_single_ended_drv = seed[0];
         check_dec;
         check_reg(k[5:0]);
      end
      fork
         host_inst.wr(6'h0c, 8'h01);
         begin @(negedge i_clk) i_set_default = 1'b1; @(negedge i_clk) i_set_default = 1'b0; end
      join
      m[0] = 8'h00;
      m[1] = 8'h1a;
      m[2] = 8'hd8;
      check_dec;
      for (k = 10; k < 13; k++) check_reg(k[5:0]);
      host_inst.wr(6'h0a, 8'h80);
      i_am_chan_enabled = 1'b0;
      i_pm_chan_enabled = 1'b1;
      repeat (2) @(negedge i_clk);
      `CHK("chan_on", 2'b01, {o_am_chan_on, o_pm_chan_on})
      i_am_chan_enabled = 1'b1;
      i_manual_chan_sel = 1'b1;
      repeat (2) @(negedge i_clk);
      `CHK("framing", 1'b1, o_framing_uses_pm)
      host_inst.wr(6'h0a, 8'h00);
      repeat (2) @(negedge i_clk);
      `CHK("framing", 1'b0, o_framing_uses_pm)
      for (i = 0; i < 2; i++) begin
         host_inst.wr(6'h0b, i ? 8'h18 : 8'h1a);
         i_tx_end = 1'b1;
         @(negedge i_clk) i_tx_end = 1'b0;
         i_carrier_tick = 1'b1;
         k = 0;
         sq = 1'b0;
         repeat (40) begin @(negedge i_clk) k += o_rx_masked; sq |= o_squelch_active; end
         i_carrier_tick = 1'b0;
         `CHK("mask_len", 1'b1, k >= 15 && k <= 17)
         `CHK("squelch", i == 0, sq)
      end
      complete_run;
   end
endmodule
bind rxcfg_bank rxcfg_bank_checker #(.SQUELCH_DELAY_CYC(SQUELCH_DELAY_CYC), .MASK_STEP_CARRIERS(MASK_STEP_CARRIERS))
   rxcfg_bank_checker_inst (.*);

// ### sim/rxcfg_host_model.sv
// Host model driving the bank's strobe register port on the falling edge.
// Tasks are called by the bench; answers are taken half a cycle after the taking edge.
`timescale 1ns/1ps
module rxcfg_host_model (
   input wire i_clk,
   input wire [7:0] i_rdata,
   input wire i_rvalid,
   output reg o_wr = 1'b0,
   output reg o_rd = 1'b0,
   output reg [5:0] o_addr = 6'h00,
   output reg [7:0] o_wdata = 8'h00
);
   task wr(input [5:0] a, input [7:0] d);
      begin
         @(negedge i_clk);
         o_wr = 1'b1;
         o_addr = a;
         o_wdata = d;
         @(negedge i_clk);
         o_wr = 1'b0;
         o_addr = ~a;
         o_wdata = ~d;
      end
   endtask
   task rd(input [5:0] a, output [7:0] d, output v);
      begin
         @(negedge i_clk);
         o_rd = 1'b1;
         o_addr = a;
         @(negedge i_clk);
         o_rd = 1'b0;
         o_addr = ~a;
         d = i_rdata;
         v = i_rvalid;
      end
   endtask
endmodule

// ### src/rxcfg_bank.v
// Receiver configuration registers 0Ah..0Ch with decoded controls, squelch and receive masking.
// Assumes a host port that presents one-cycle write/read strobes with address and data,
// a carrier-period enable pulse, and end-of-transmit / set-default pulses from the device core.
`timescale 1ns/1ps
`include "rxcfg_defines.vh"

module rxcfg_bank #(
   parameter SQUELCH_DELAY_CYC = `RXCFG_SQUELCH_DELAY_CYC,
   parameter MASK_STEP_CARRIERS = `RXCFG_MASK_STEP_CARRIERS
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // Host register port
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [`RXCFG_ADDR_W-1:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   output reg [7:0] o_reg_rdata,
   output reg o_reg_rvalid,
   // Device core events and settings
   input wire i_set_default,
   input wire i_tx_end,
   input wire i_carrier_tick,
   input wire [7:0] i_mask_rx_steps,
   input wire i_am_chan_enabled,
   input wire i_pm_chan_enabled,
   input wire i_manual_chan_sel,
   input wire i_single_ended_drv,
   // Decoded analog controls
   output reg o_am_chan_on,
   output reg o_pm_chan_on,
   output reg o_framing_uses_pm,
   output reg o_am_demod_mixer,
   output reg [2:0] o_lowpass_code,
   output reg o_zero_setting_high,
   output reg o_zero_setting_mid,
   output reg o_zero_setting_low,
   output reg o_receiver_low_power,
   output reg o_low_freq_input_split,
   output reg o_lf_on_input,
   output reg o_agc_enable,
   output reg o_agc_whole_period,
   output reg o_agc_alg_reset,
   output reg o_pm_mixer_clock_source,
   output reg [2:0] o_am_first_stage_gain,
   output reg [2:0] o_pm_first_stage_gain,
   output reg o_clip_stages,
   output reg o_nfc_forced_gain,
   // Receive timing
   output reg o_squelch_active,
   output reg o_rx_masked
);

   reg [7:0] channel_filter_cfg;
   reg [7:0] mode_gain_cfg;
   reg [7:0] first_gain_cfg;

   // Register writes; set-default has priority over a same-cycle write
   reg [7:0] next_channel_filter_cfg;
   reg [7:0] next_mode_gain_cfg;
   reg [7:0] next_first_gain_cfg;
   wire wr_channel_filter = i_reg_wr && (i_reg_addr == `RXCFG_OFS_CHANNEL_FILTER);
   wire wr_mode_gain = i_reg_wr && (i_reg_addr == `RXCFG_OFS_MODE_GAIN);
   wire wr_first_gain = i_reg_wr && (i_reg_addr == `RXCFG_OFS_FIRST_GAIN);

   always @* begin
      next_channel_filter_cfg = channel_filter_cfg;
      next_mode_gain_cfg = mode_gain_cfg;
      next_first_gain_cfg = first_gain_cfg;
      if (i_set_default) begin
         next_channel_filter_cfg = `RXCFG_RST_CHANNEL_FILTER;
         next_mode_gain_cfg = `RXCFG_RST_MODE_GAIN;
         next_first_gain_cfg = `RXCFG_RST_FIRST_GAIN;
      end else begin
         if (wr_channel_filter) begin
            next_channel_filter_cfg = i_reg_wdata;
         end
         if (wr_mode_gain) begin
            next_mode_gain_cfg = i_reg_wdata;
         end
         if (wr_first_gain) begin
            next_first_gain_cfg = i_reg_wdata;
         end
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         channel_filter_cfg <= `RXCFG_RST_CHANNEL_FILTER;
         mode_gain_cfg <= `RXCFG_RST_MODE_GAIN;
         first_gain_cfg <= `RXCFG_RST_FIRST_GAIN;
      end else begin
         channel_filter_cfg <= next_channel_filter_cfg;
         mode_gain_cfg <= next_mode_gain_cfg;
         first_gain_cfg <= next_first_gain_cfg;
      end
   end

   // Read data, one cycle after the strobe; unmapped addresses read zero
   reg [7:0] next_rdata;
   always @* begin
      case (i_reg_addr)
         `RXCFG_OFS_CHANNEL_FILTER: next_rdata = channel_filter_cfg;
         `RXCFG_OFS_MODE_GAIN: next_rdata = mode_gain_cfg;
         `RXCFG_OFS_FIRST_GAIN: next_rdata = first_gain_cfg;
         default: next_rdata = 8'h00;
      endcase
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
         end
      end
   end

   // Decoded controls, registered
   wire pick_pm = channel_filter_cfg[`RXCFG_BIT_CHANNEL_PICK];
   wire one_chan = i_am_chan_enabled ^ i_pm_chan_enabled;
   wire both_chan = i_am_chan_enabled & i_pm_chan_enabled;

   reg next_am_chan_on;
   reg next_pm_chan_on;
   reg next_framing_uses_pm;
   reg next_am_demod_mixer;
   reg [2:0] next_lowpass_code;
   reg next_zero_setting_high;
   reg next_zero_setting_mid;
   reg next_zero_setting_low;
   reg next_receiver_low_power;
   reg next_low_freq_input_split;
   reg next_lf_on_input;
   reg next_agc_enable;
   reg next_agc_whole_period;
   reg next_agc_alg_reset;
   reg next_pm_mixer_clock_source;
   reg [2:0] next_am_first_stage_gain;
   reg [2:0] next_pm_first_stage_gain;
   reg next_clip_stages;
   reg next_nfc_forced_gain;

   always @* begin
      // Single channel: the pick bit chooses which one runs; both: both run
      next_am_chan_on = both_chan | (one_chan & ~pick_pm);
      next_pm_chan_on = both_chan | (one_chan & pick_pm);
      if (both_chan) begin
         // Automatic selection is decided elsewhere; only manual mode follows the bit
         next_framing_uses_pm = i_manual_chan_sel ? pick_pm : o_framing_uses_pm;
      end else begin
         next_framing_uses_pm = one_chan & pick_pm;
      end
      next_am_demod_mixer = channel_filter_cfg[`RXCFG_BIT_AM_DEMOD];
      next_lowpass_code = channel_filter_cfg[`RXCFG_LP_HI:`RXCFG_LP_LO];
      next_zero_setting_high = channel_filter_cfg[`RXCFG_ZERO_HI];
      next_zero_setting_mid = channel_filter_cfg[`RXCFG_ZERO_LO + 1];
      next_zero_setting_low = channel_filter_cfg[`RXCFG_ZERO_LO];
      next_receiver_low_power = mode_gain_cfg[`RXCFG_BIT_LOW_POWER];
      next_low_freq_input_split = mode_gain_cfg[`RXCFG_BIT_LF_SPLIT];
      next_lf_on_input = mode_gain_cfg[`RXCFG_BIT_LF_ENABLE];
      next_agc_enable = mode_gain_cfg[`RXCFG_BIT_AGC_EN];
      next_agc_whole_period = mode_gain_cfg[`RXCFG_BIT_AGC_MODE];
      next_agc_alg_reset = mode_gain_cfg[`RXCFG_BIT_AGC_ALG];
      // Single-ended driving has no usable driver output for the mixer
      next_pm_mixer_clock_source = mode_gain_cfg[`RXCFG_BIT_PM_MIX_CLK] | i_single_ended_drv;
      next_am_first_stage_gain = first_gain_cfg[`RXCFG_AM_GAIN_HI:`RXCFG_AM_GAIN_LO];
      next_pm_first_stage_gain = first_gain_cfg[`RXCFG_PM_GAIN_HI:`RXCFG_PM_GAIN_LO];
      next_clip_stages = first_gain_cfg[`RXCFG_BIT_CLIP];
      next_nfc_forced_gain = first_gain_cfg[`RXCFG_BIT_NFC_GAIN];
   end

   // Outputs decoded from the channel and filter register
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_am_chan_on <= 1'b0;
         o_pm_chan_on <= 1'b0;
         o_framing_uses_pm <= 1'b0;
         o_am_demod_mixer <= 1'b0;
         o_lowpass_code <= 3'h0;
         o_zero_setting_high <= 1'b0;
         o_zero_setting_mid <= 1'b0;
         o_zero_setting_low <= 1'b0;
      end else begin
         o_am_chan_on <= next_am_chan_on;
         o_pm_chan_on <= next_pm_chan_on;
         o_framing_uses_pm <= next_framing_uses_pm;
         o_am_demod_mixer <= next_am_demod_mixer;
         o_lowpass_code <= next_lowpass_code;
         o_zero_setting_high <= next_zero_setting_high;
         o_zero_setting_mid <= next_zero_setting_mid;
         o_zero_setting_low <= next_zero_setting_low;
      end
   end

   // Outputs decoded from the mode and gain-control register
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_receiver_low_power <= 1'b0;
         o_low_freq_input_split <= 1'b0;
         o_lf_on_input <= 1'b0;
         o_agc_enable <= 1'b0;
         o_agc_whole_period <= 1'b0;
         o_agc_alg_reset <= 1'b0;
         o_pm_mixer_clock_source <= 1'b0;
      end else begin
         o_receiver_low_power <= next_receiver_low_power;
         o_low_freq_input_split <= next_low_freq_input_split;
         o_lf_on_input <= next_lf_on_input;
         o_agc_enable <= next_agc_enable;
         o_agc_whole_period <= next_agc_whole_period;
         o_agc_alg_reset <= next_agc_alg_reset;
         o_pm_mixer_clock_source <= next_pm_mixer_clock_source;
      end
   end

   // Outputs decoded from the first-stage gain register
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_am_first_stage_gain <= 3'h0;
         o_pm_first_stage_gain <= 3'h0;
         o_clip_stages <= 1'b0;
         o_nfc_forced_gain <= 1'b0;
      end else begin
         o_am_first_stage_gain <= next_am_first_stage_gain;
         o_pm_first_stage_gain <= next_pm_first_stage_gain;
         o_clip_stages <= next_clip_stages;
         o_nfc_forced_gain <= next_nfc_forced_gain;
      end
   end

   // Mask receive timer: steps of MASK_STEP_CARRIERS carrier periods, at least four steps
   localparam CAR_W = 7;
   localparam DLY_W = 13;
   reg [7:0] mask_steps_left;
   reg [CAR_W-1:0] carrier_cnt;
   reg [DLY_W-1:0] squelch_dly;
   reg squelch_wait;
   wire [7:0] mask_load = (i_mask_rx_steps < `RXCFG_MASK_MIN_STEPS) ? `RXCFG_MASK_MIN_STEPS : i_mask_rx_steps;
   wire step_done = i_carrier_tick && (carrier_cnt == MASK_STEP_CARRIERS[CAR_W-1:0] - 1'b1);
   wire mask_expire = o_rx_masked && step_done && (mask_steps_left == 8'h01);

   // A new transmit end restarts the mask even while one is running
   reg [7:0] next_mask_steps_left;
   reg [CAR_W-1:0] next_carrier_cnt;
   reg next_rx_masked;

   always @* begin
      next_mask_steps_left = mask_steps_left;
      next_carrier_cnt = carrier_cnt;
      next_rx_masked = o_rx_masked;
      if (i_tx_end) begin
         next_mask_steps_left = mask_load;
         next_carrier_cnt = {CAR_W{1'b0}};
         next_rx_masked = 1'b1;
      end else if (o_rx_masked && i_carrier_tick) begin
         if (step_done) begin
            next_carrier_cnt = {CAR_W{1'b0}};
            next_mask_steps_left = mask_steps_left - 8'h01;
            next_rx_masked = ~mask_expire;
         end else begin
            next_carrier_cnt = carrier_cnt + 1'b1;
         end
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_steps_left <= 8'h00;
         carrier_cnt <= {CAR_W{1'b0}};
         o_rx_masked <= 1'b0;
      end else begin
         mask_steps_left <= next_mask_steps_left;
         carrier_cnt <= next_carrier_cnt;
         o_rx_masked <= next_rx_masked;
      end
   end

   reg [DLY_W-1:0] next_squelch_dly;
   reg next_squelch_wait;
   reg next_squelch_active;

   // Automatic squelch: fixed delay after transmit end, released by mask expiry
   // The delay counter must hold the full start time at the block clock, hence its width
   always @* begin
      next_squelch_dly = squelch_dly;
      next_squelch_wait = squelch_wait;
      next_squelch_active = o_squelch_active;
      if (i_tx_end) begin
         next_squelch_dly = SQUELCH_DELAY_CYC[DLY_W-1:0] - 1'b1;
         next_squelch_wait = mode_gain_cfg[`RXCFG_BIT_AUTO_SQUELCH];
         next_squelch_active = 1'b0;
      end else if (mask_expire) begin
         next_squelch_wait = 1'b0;
         next_squelch_active = 1'b0;
      end else if (squelch_wait) begin
         if (squelch_dly == {DLY_W{1'b0}}) begin
            next_squelch_wait = 1'b0;
            next_squelch_active = 1'b1;
         end else begin
            next_squelch_dly = squelch_dly - 1'b1;
         end
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         squelch_dly <= {DLY_W{1'b0}};
         squelch_wait <= 1'b0;
         o_squelch_active <= 1'b0;
      end else begin
         squelch_dly <= next_squelch_dly;
         squelch_wait <= next_squelch_wait;
         o_squelch_active <= next_squelch_active;
      end
   end

endmodule

// ### src/rxcfg_defines.vh
// Offsets, field positions, reset values and timing counts of the receiver configuration bank.
// Included by the bank module and its checker; holds definitions only.
`ifndef RXCFG_DEFINES_VH
`define RXCFG_DEFINES_VH

`define RXCFG_ADDR_W 6
`define RXCFG_OFS_CHANNEL_FILTER 6'h0a
`define RXCFG_OFS_MODE_GAIN 6'h0b
`define RXCFG_OFS_FIRST_GAIN 6'h0c

`define RXCFG_RST_CHANNEL_FILTER 8'h00
`define RXCFG_RST_MODE_GAIN 8'h1a
`define RXCFG_RST_FIRST_GAIN 8'hd8

`define RXCFG_BIT_CHANNEL_PICK 7
`define RXCFG_BIT_AM_DEMOD 6
`define RXCFG_LP_HI 5
`define RXCFG_LP_LO 3
`define RXCFG_ZERO_HI 2
`define RXCFG_ZERO_LO 0

`define RXCFG_BIT_LOW_POWER 7
`define RXCFG_BIT_LF_SPLIT 6
`define RXCFG_BIT_LF_ENABLE 5
`define RXCFG_BIT_AGC_EN 4
`define RXCFG_BIT_AGC_MODE 3
`define RXCFG_BIT_AGC_ALG 2
`define RXCFG_BIT_AUTO_SQUELCH 1
`define RXCFG_BIT_PM_MIX_CLK 0

`define RXCFG_AM_GAIN_HI 7
`define RXCFG_AM_GAIN_LO 5
`define RXCFG_PM_GAIN_HI 4
`define RXCFG_PM_GAIN_LO 2
`define RXCFG_BIT_CLIP 1
`define RXCFG_BIT_NFC_GAIN 0

// Squelch start delay after end of transmit, in picoseconds, and its cycle count at 5000 ps
`define RXCFG_SQUELCH_DELAY_PS 18880000
`define RXCFG_CLK_PERIOD_PS 5000
`define RXCFG_SQUELCH_DELAY_CYC ((`RXCFG_SQUELCH_DELAY_PS + `RXCFG_CLK_PERIOD_PS - 1) / `RXCFG_CLK_PERIOD_PS)
`define RXCFG_MASK_STEP_CARRIERS 64
`define RXCFG_MASK_MIN_STEPS 8'h04

`endif
